// File: rtl/shadow_pkg.sv
// constants and types shared by the i2c shadow register port
package shadow_pkg;
  localparam int WORD_W = 18;
  localparam int SHADOW_CNT = 24;
  localparam logic [6:0] TARGET_ADDR = 7'h55;
  localparam logic [7:0] SHADOW_OFS = 8'h40;
  localparam logic [5:0] SHADOW_FIRST = 6'h08;
  localparam logic [5:0] SHADOW_LAST = 6'h1f;
  localparam logic [7:0] SHADOW_LO_ADDR = SHADOW_OFS + {2'h0, SHADOW_FIRST};
  localparam logic [7:0] SHADOW_HI_ADDR = SHADOW_OFS + {2'h0, SHADOW_LAST};
  localparam logic [7:0] NV_TOP = 8'h3f;
  localparam logic [5:0] LOCK_LOW_LAST = 6'h05;
  localparam logic [5:0] LOCK_WORD = 6'h1f;
  localparam logic [7:0] NV_RESERVED_WORD_A = 8'h06;
  localparam logic [7:0] NV_RESERVED_WORD_B = 8'h07;
  localparam logic [7:0] SPEED_INPUT_CONFIG = 8'h48;
  localparam logic [7:0] STARTUP_ACCEL_CONFIG = 8'h49;
  localparam logic [WORD_W-1:0] SHADOW_RESET = 18'h0_0000;
  localparam int BAND_BIT = 15;
  localparam int ORDER_BIT = 14;
  localparam int SPAN_BIT = 13;
  localparam int SRC_HI = 12;
  localparam int SRC_LO = 11;
  localparam int MAX_SPEED_HI = 10;
  localparam int SLOPE_HI = 17;
  localparam int SLOPE_LO = 8;
  localparam int RATE_HI = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  localparam logic [1:0] BYTES_PER_WORD = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
    ST_WDATA, ST_ACK_DATA, ST_RDATA, ST_RACK, ST_WAIT
  } i2c_state_e;
  typedef enum logic [1:0] {OWN_BOOT, OWN_I2C, OWN_CURVE} nv_owner_e;
endpackage : shadow_pkg

// File: rtl/scl_sda_if.sv
// bus line events passed from the edge detector to the port logic
interface scl_sda_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport src (output scl_rise, scl_fall, start, stop, sda);
  modport dst (input scl_rise, scl_fall, start, stop, sda);
endinterface : scl_sda_if

// File: rtl/i2c_line_edges.sv
// clock edge and start/stop detection on the serial lines
module i2c_line_edges (
  input wire logic clk_in,    // core clock
  input wire logic arst_n_in, // async reset, active low
  input wire logic scl_in,    // serial clock level
  input wire logic sda_in,    // serial data level
  scl_sda_if.src ev           // decoded line events
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign ev.scl_rise = scl_in & ~scl_q;
  assign ev.scl_fall = ~scl_in & scl_q;
  // data moving while the clock stays high marks start or stop
  assign ev.start = scl_in & scl_q & sda_q & ~sda_in;
  assign ev.stop = scl_in & scl_q & ~sda_q & sda_in;
  assign ev.sda = sda_in;
endmodule : i2c_line_edges

// File: rtl/shadow_cell.sv
// one shadow word, loaded at boot or by a bus write
module shadow_cell #(
  parameter int unsigned WIDTH = 18
) (
  input wire logic clk_in,              // core clock
  input wire logic arst_n_in,           // async reset, active low
  input wire logic load_in,             // store data_in this cycle
  input wire logic [WIDTH-1:0] data_in, // value to store
  output logic [WIDTH-1:0] q_out        // stored word
);
  if (WIDTH < 1) begin : g_bad_width
    $error("shadow_cell width must be at least one bit");
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q_out <= '0;
    end else if (load_in) begin
      q_out <= data_in;
    end
  end
endmodule : shadow_cell

// File: rtl/i2c_shadow_register_port.sv
// i2c target port, shadow register bank and nonvolatile word access
// Summary of operation
// - answer only target address 0x55
// - copy nonvolatile words to shadows at power-up
// - shadow writes steer operation at once
// - shadow edits vanish; nonvolatile edits wait
// - curve data read straight from nonvolatile store
// - shadow address is word address plus 64
// - words 0-7 and 32-63 lack shadows
// - write: address, register byte, three bytes
// - read: set address, stop, then read three
// - host ack after last byte: next register
// - keep incrementing until host nacks
// - words 0-5 and 31 never written
// - word 72 bit 15 selects pwm band
// - word 72 bit 14 sets phase order
// - word 72 bit 13 selects acceleration span
// - word 72 bits 12:11 pick speed source
// - word 72 bits 10:0 hold max speed
// - word 73 holds slope and acceleration rate
module i2c_shadow_register_port
  import shadow_pkg::*;
(
  input wire logic clk_in,                    // core clock, 200 MHz
  input wire logic arst_n_in,                 // async reset, active low
  input wire logic scl_in,                    // serial clock
  input wire logic sda_in,                    // serial data line level
  output logic sda_out,                       // data drive value, always low
  output logic sda_oe_out,                    // high while pulling data low
  output logic nv_rd_out,                     // nonvolatile read strobe
  output logic nv_wr_out,                     // nonvolatile write strobe
  output logic [5:0] nv_addr_out,             // nonvolatile word address
  output logic [WORD_W-1:0] nv_wdata_out,     // nonvolatile write data
  input wire logic [WORD_W-1:0] nv_rdata_in,  // read data, cycle after strobe
  input wire logic curve_req_in,              // curve fetch request pulse
  input wire logic [5:0] curve_addr_in,       // curve word address
  output logic curve_valid_out,               // curve data valid pulse
  output logic [WORD_W-1:0] curve_data_out,   // curve word
  output logic [SHADOW_CNT*WORD_W-1:0] shadow_bank_out, // all shadows
  output logic boot_done_out,                 // shadows loaded
  output logic input_pwm_band_sel_out,        // 1: low pwm band
  output logic phase_order_out,               // 1: a-b-c rotation
  output logic accel_span_out,                // 1: narrow span
  output logic [1:0] speed_src_out,           // speed input source
  output logic [10:0] max_speed_out,          // max speed code
  output logic [9:0] quiet_slope_out,         // quiet start slope
  output logic [7:0] accel_rate_out           // startup acceleration
);
  scl_sda_if ev ();

  i2c_line_edges u_edges (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev.src)
  );

  i2c_state_e state;
  nv_owner_e owner;
  nv_owner_e owner_dly;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shift;
  logic [7:0] reg_addr;
  logic [15:0] wbuf;
  logic read_dir;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] shadow_q [SHADOW_CNT];
  logic [SHADOW_CNT-1:0] shadow_ld;
  logic [WORD_W-1:0] shadow_d;
  logic boot_active;
  logic [5:0] boot_idx;
  logic rd_dly;
  logic [5:0] addr_dly;
  logic i2c_rd_pend;
  logic i2c_wr_pend;
  logic curve_pend;
  logic [5:0] pend_addr;
  logic [5:0] curve_addr_q;
  logic [WORD_W-1:0] wr_word_q;
  logic rx_state;
  logic rx_done;
  logic wr_last;
  logic shadow_commit;
  logic nv_commit;
  logic addr_rd_hit;
  logic inc_now;
  logic fetch_now;
  logic [7:0] fetch_addr;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [WORD_W-1:0] commit_word;
  logic boot_load;

  function automatic logic is_shadow(input logic [7:0] a);
    return (a >= SHADOW_LO_ADDR) && (a <= SHADOW_HI_ADDR);
  endfunction : is_shadow

  function automatic logic is_locked(input logic [7:0] a);
    return (a <= {2'h0, LOCK_LOW_LAST}) || (a == {2'h0, LOCK_WORD});
  endfunction : is_locked

  function automatic logic [4:0] slot_of(input logic [7:0] a);
    return 5'(a - SHADOW_LO_ADDR);
  endfunction : slot_of

  assign rx_state = (state == ST_ADDR) || (state == ST_REG) || (state == ST_WDATA);
  assign rx_done = ev.scl_fall && (bit_cnt == BYTE_BITS);
  assign wr_last = (state == ST_WDATA) && rx_done && (byte_idx == LAST_BYTE);
  assign commit_word = {wbuf[9:0], shift};
  assign shadow_commit = wr_last && is_shadow(reg_addr);
  assign nv_commit = wr_last && (reg_addr <= NV_TOP) && !is_locked(reg_addr);
  assign addr_rd_hit = (state == ST_ADDR) && rx_done && (shift[7:1] == TARGET_ADDR)
                       && shift[0];
  assign inc_now = (state == ST_RACK) && ev.scl_rise && !ev.sda
                   && (byte_idx == LAST_BYTE);
  assign fetch_now = addr_rd_hit || inc_now;
  assign fetch_addr = inc_now ? reg_addr + 8'h01 : reg_addr;
  assign tx_load = ev.scl_fall && (((state == ST_ACK_ADDR) && read_dir)
                   || (state == ST_RACK));
  assign boot_load = rd_dly && (owner_dly == OWN_BOOT);

  always_comb begin
    unique case (byte_idx)
      2'h0: tx_byte = {6'h00, rd_word[17:16]};
      2'h1: tx_byte = rd_word[15:8];
      default: tx_byte = rd_word[7:0];
    endcase
  end

  // one shared data path; boot and bus writes never overlap
  always_comb begin
    shadow_d = boot_load ? nv_rdata_in : commit_word;
    for (int i = 0; i < SHADOW_CNT; i++) begin
      shadow_ld[i] = (boot_load && (5'(addr_dly - SHADOW_FIRST) == 5'(i)))
                     || (shadow_commit && (slot_of(reg_addr) == 5'(i)));
    end
  end

  for (genvar g = 0; g < SHADOW_CNT; g++) begin : g_shadow
    shadow_cell #(.WIDTH(WORD_W)) u_cell (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .load_in(shadow_ld[g]),
      .data_in(shadow_d),
      .q_out(shadow_q[g])
    );
    assign shadow_bank_out[g*WORD_W +: WORD_W] = shadow_q[g];
  end

  assign input_pwm_band_sel_out = shadow_q[0][BAND_BIT];
  assign phase_order_out = shadow_q[0][ORDER_BIT];
  assign accel_span_out = shadow_q[0][SPAN_BIT];
  assign speed_src_out = shadow_q[0][SRC_HI:SRC_LO];
  assign max_speed_out = shadow_q[0][MAX_SPEED_HI:0];
  assign quiet_slope_out = shadow_q[1][SLOPE_HI:SLOPE_LO];
  assign accel_rate_out = shadow_q[1][RATE_HI:0];
  // open-drain line: only the enable moves
  assign sda_out = 1'b0;

  // protocol sequencer; starts are ignored until the shadows are loaded
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      sda_oe_out <= 1'b0;
      reg_addr <= 8'h00;
      read_dir <= 1'b0;
    end else if (ev.stop) begin
      state <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else if (ev.start) begin
      state <= boot_done_out ? ST_ADDR : ST_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      sda_oe_out <= 1'b0;
    end else begin
      if (ev.scl_rise && rx_state) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      unique case (state)
        ST_IDLE, ST_WAIT: begin
        end
        ST_ADDR: if (rx_done) begin
          if (shift[7:1] == TARGET_ADDR) begin
            state <= ST_ACK_ADDR;
            sda_oe_out <= 1'b1;
            read_dir <= shift[0];
          end else begin
            state <= ST_WAIT;
          end
        end
        ST_ACK_ADDR: if (ev.scl_fall) begin
          bit_cnt <= read_dir ? 4'h1 : 4'h0;
          state <= read_dir ? ST_RDATA : ST_REG;
          sda_oe_out <= read_dir ? ~tx_byte[7] : 1'b0;
        end
        ST_REG: if (rx_done) begin
          state <= ST_ACK_REG;
          sda_oe_out <= 1'b1;
          reg_addr <= shift;
        end
        ST_ACK_REG: if (ev.scl_fall) begin
          state <= ST_WDATA;
          sda_oe_out <= 1'b0;
          bit_cnt <= 4'h0;
          byte_idx <= 2'h0;
        end
        ST_WDATA: if (rx_done) begin
          state <= ST_ACK_DATA;
          // bytes past the third are refused with a nack
          sda_oe_out <= (byte_idx < BYTES_PER_WORD);
          if (byte_idx != BYTES_PER_WORD) begin
            byte_idx <= byte_idx + 2'h1;
          end
        end
        ST_ACK_DATA: if (ev.scl_fall) begin
          state <= ST_WDATA;
          sda_oe_out <= 1'b0;
          bit_cnt <= 4'h0;
        end
        ST_RDATA: if (ev.scl_fall) begin
          if (bit_cnt == BYTE_BITS) begin
            state <= ST_RACK;
            sda_oe_out <= 1'b0;
          end else begin
            sda_oe_out <= ~shift[7];
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        ST_RACK: if (ev.scl_rise) begin
          if (ev.sda) begin
            state <= ST_WAIT;
          end else if (byte_idx == LAST_BYTE) begin
            byte_idx <= 2'h0;
            reg_addr <= reg_addr + 8'h01;
          end else begin
            byte_idx <= byte_idx + 2'h1;
          end
        end else if (ev.scl_fall) begin
          state <= ST_RDATA;
          sda_oe_out <= ~tx_byte[7];
          bit_cnt <= 4'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift <= 8'h00;
    end else if (ev.scl_rise && rx_state) begin
      shift <= {shift[6:0], ev.sda};
    end else if (tx_load) begin
      shift <= {tx_byte[6:0], 1'b0};
    end else if ((state == ST_RDATA) && ev.scl_fall) begin
      shift <= {shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wbuf <= 16'h0000;
    end else if ((state == ST_WDATA) && rx_done) begin
      wbuf <= {wbuf[7:0], shift};
    end
  end

  // read word: shadows answer at once, stored words via the port
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_word <= SHADOW_RESET;
    end else if (fetch_now && is_shadow(fetch_addr)) begin
      rd_word <= shadow_q[slot_of(fetch_addr)];
    end else if (fetch_now && (fetch_addr > NV_TOP)) begin
      rd_word <= SHADOW_RESET;
    end else if (rd_dly && (owner_dly == OWN_I2C)) begin
      rd_word <= nv_rdata_in;
    end
  end

  // nonvolatile port: boot first, then bus write, bus read, curve
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      boot_active <= 1'b1;
      boot_idx <= SHADOW_FIRST;
      nv_rd_out <= 1'b0;
      nv_wr_out <= 1'b0;
      nv_addr_out <= 6'h00;
      nv_wdata_out <= SHADOW_RESET;
      owner <= OWN_BOOT;
      i2c_rd_pend <= 1'b0;
      i2c_wr_pend <= 1'b0;
      curve_pend <= 1'b0;
      pend_addr <= 6'h00;
      curve_addr_q <= 6'h00;
      wr_word_q <= SHADOW_RESET;
    end else begin
      nv_rd_out <= 1'b0;
      nv_wr_out <= 1'b0;
      if (boot_active) begin
        nv_rd_out <= 1'b1;
        nv_addr_out <= boot_idx;
        owner <= OWN_BOOT;
        boot_idx <= boot_idx + 6'h01;
        boot_active <= (boot_idx != SHADOW_LAST);
      end else if (i2c_wr_pend) begin
        nv_wr_out <= 1'b1;
        nv_addr_out <= pend_addr;
        nv_wdata_out <= wr_word_q;
      end else if (i2c_rd_pend) begin
        nv_rd_out <= 1'b1;
        nv_addr_out <= pend_addr;
        owner <= OWN_I2C;
      end else if (curve_pend) begin
        nv_rd_out <= 1'b1;
        nv_addr_out <= curve_addr_q;
        owner <= OWN_CURVE;
      end
      // a new request in the serving cycle keeps its flag set
      if (nv_commit) begin
        i2c_wr_pend <= 1'b1;
        pend_addr <= reg_addr[5:0];
        wr_word_q <= commit_word;
      end else if (fetch_now && (fetch_addr <= NV_TOP) && !is_shadow(fetch_addr)) begin
        i2c_rd_pend <= 1'b1;
        pend_addr <= fetch_addr[5:0];
      end
      if (!boot_active && i2c_wr_pend && !nv_commit) begin
        i2c_wr_pend <= 1'b0;
      end
      if (!boot_active && !i2c_wr_pend && i2c_rd_pend && !fetch_now) begin
        i2c_rd_pend <= 1'b0;
      end
      if (curve_req_in) begin
        curve_pend <= 1'b1;
        curve_addr_q <= curve_addr_in;
      end else if (!boot_active && !i2c_wr_pend && !i2c_rd_pend) begin
        curve_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_dly <= 1'b0;
      addr_dly <= 6'h00;
      owner_dly <= OWN_BOOT;
      boot_done_out <= 1'b0;
      curve_valid_out <= 1'b0;
      curve_data_out <= SHADOW_RESET;
    end else begin
      rd_dly <= nv_rd_out;
      addr_dly <= nv_addr_out;
      owner_dly <= owner;
      curve_valid_out <= rd_dly && (owner_dly == OWN_CURVE);
      if (rd_dly && (owner_dly == OWN_CURVE)) begin
        curve_data_out <= nv_rdata_in;
      end
      if (boot_load && (addr_dly == SHADOW_LAST)) begin
        boot_done_out <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_own_addr;
    $rose(sda_oe_out) && (state == ST_ACK_ADDR) |-> $past(shift[7:1]) == TARGET_ADDR;
  endproperty
  a_own_addr: assert property (p_own_addr) else $error("ack to foreign address");
  property p_boot_copy;
    boot_load && (addr_dly == SHADOW_FIRST) |=> shadow_q[0] == $past(nv_rdata_in);
  endproperty
  a_boot_copy: assert property (p_boot_copy) else $error("boot copy lost");
  property p_write_now;
    shadow_commit && (reg_addr == SPEED_INPUT_CONFIG)
      |=> shadow_q[0] == $past(commit_word) && max_speed_out == $past(commit_word[10:0]);
  endproperty
  a_write_now: assert property (p_write_now) else $error("shadow write late");
  property p_nv_no_effect;
    nv_wr_out |=> $stable(shadow_bank_out);
  endproperty
  a_nv_no_effect: assert property (p_nv_no_effect) else $error("nv write moved a shadow");
  property p_curve_direct;
    rd_dly && (owner_dly == OWN_CURVE) |=> curve_valid_out && curve_data_out == $past(nv_rdata_in);
  endproperty
  a_curve_direct: assert property (p_curve_direct) else $error("curve word lost");
  property p_no_low_shadow;
    (|shadow_ld) && !boot_load |-> reg_addr >= SHADOW_LO_ADDR && reg_addr <= SHADOW_HI_ADDR;
  endproperty
  a_no_low_shadow: assert property (p_no_low_shadow) else $error("shadow outside range");
  property p_locked;
    nv_wr_out |-> !is_locked({2'h0, nv_addr_out});
  endproperty
  a_locked: assert property (p_locked) else $error("locked word written");
  property p_auto_inc;
    inc_now |=> reg_addr == $past(reg_addr) + 8'h01 && byte_idx == 2'h0;
  endproperty
  a_auto_inc: assert property (p_auto_inc) else $error("no auto increment");
  property p_nack_stop;
    (state == ST_RACK) && ev.scl_rise && ev.sda |=> state == ST_WAIT ##1 !sda_oe_out;
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("nack ignored");
  property p_upper_zero;
    tx_load && (byte_idx == 2'h0) |=> sda_oe_out && shift[7:3] == 5'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
  property p_data_ack;
    (state == ST_WDATA) && rx_done && (byte_idx < BYTES_PER_WORD)
      |=> sda_oe_out && state == ST_ACK_DATA;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data byte not acked");
  c_commit: cover property (shadow_commit);
  c_auto_inc: cover property (inc_now);
  c_boot: cover property ($rose(boot_done_out));
  c_curve: cover property (curve_valid_out);
endmodule : i2c_shadow_register_port

// File: verif/nv_store_model.sv
// nonvolatile word store answering the port's read and write strobes
module nv_store_model
  import shadow_pkg::*;
(
  input wire logic clk_in,                // core clock
  input wire logic rd_in,                 // read strobe
  input wire logic wr_in,                 // write strobe
  input wire logic [5:0] addr_in,         // word address
  input wire logic [WORD_W-1:0] wdata_in, // write data
  output logic [WORD_W-1:0] rdata_out     // read data, cycle after strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_W-1:0] mem [64];
  initial begin
    for (int k = 0; k < 64; k++) begin
      mem[k] = {k[1:0], k[5:0], 4'ha, k[5:0]};
    end
    rdata_out = 18'h0_0000;
  end
  // data is valid only the cycle after a strobe; flipping it otherwise exposes late sampling
  always @(posedge clk_in) begin
    if (rd_in) begin
      rdata_out <= mem[addr_in];
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule : nv_store_model

// File: verif/i2c_shadow_register_port_tb.sv
// self-checking bench for the i2c shadow register port
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module i2c_shadow_register_port_tb
  import shadow_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] W72 = 18'h0_a9c5;
  localparam logic [17:0] W73 = 18'h2_c35e;
  localparam logic [17:0] W9 = 18'h2_4681;
  logic clk_in, arst_n_in, scl, sda_h, sda_out, sda_oe, nv_rd, nv_wr;
  logic curve_req, curve_valid, boot_done, band, order, span;
  logic [5:0] nv_addr, curve_addr, wr_addr;
  logic [17:0] nv_wdata, nv_rdata, curve_data;
  logic [SHADOW_CNT*WORD_W-1:0] bank;
  logic [1:0] src;
  logic [10:0] maxs;
  logic [9:0] slope;
  logic [7:0] rate;
  wire sda_wire = (sda_oe ? sda_out : 1'b1) & sda_h;
  int fail_count = 0;
  int checks = 0;
  int wr_cnt = 0;
  i2c_shadow_register_port u_i2c_shadow_register_port (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe),
    .nv_rd_out(nv_rd), .nv_wr_out(nv_wr), .nv_addr_out(nv_addr), .nv_wdata_out(nv_wdata),
    .nv_rdata_in(nv_rdata), .curve_req_in(curve_req), .curve_addr_in(curve_addr),
    .curve_valid_out(curve_valid), .curve_data_out(curve_data), .shadow_bank_out(bank),
    .boot_done_out(boot_done), .input_pwm_band_sel_out(band), .phase_order_out(order),
    .accel_span_out(span), .speed_src_out(src), .max_speed_out(maxs),
    .quiet_slope_out(slope), .accel_rate_out(rate));
  nv_store_model u_nv_store_model (.clk_in(clk_in), .rd_in(nv_rd), .wr_in(nv_wr),
    .addr_in(nv_addr), .wdata_in(nv_wdata), .rdata_out(nv_rdata));
  always @(posedge clk_in) begin
    if (nv_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= nv_addr;
    end
  end
  function automatic logic [17:0] pat(input int k);
    return {k[1:0], k[5:0], 4'ha, k[5:0]};
  endfunction : pat
  task automatic tick();
    repeat (4) @(posedge clk_in);
  endtask : tick
  task automatic bit_io(input logic b, output logic s);
    sda_h <= b;
    tick();
    scl <= 1'b1;
    tick();
    s = sda_wire;
    scl <= 1'b0;
    tick();
  endtask : bit_io
  task automatic start();
    sda_h <= 1'b1;
    scl <= 1'b1;
    tick();
    sda_h <= 1'b0;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_h <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_h <= 1'b1;
    tick();
  endtask : stop
  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(last, a);
  endtask : xfer
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [17:0] d,
                        input logic ok);
    logic [7:0] r;
    logic a;
    logic [7:0] bs [3];
    bs = '{{6'h00, d[17:16]}, d[15:8], d[7:0]};
    start();
    xfer({dev, 1'b0}, 1'b1, r, a);
    `CHK("address ack", (ok ? 1'b0 : 1'b1), a)
    if (ok) begin
      xfer(ra, 1'b1, r, a);
      `CHK("register ack", 1'b0, a)
      for (int i = 0; i < 3; i++) begin
        xfer(bs[i], 1'b1, r, a);
        `CHK("data ack", 1'b0, a)
      end
    end
    stop();
  endtask : wr_reg
  task automatic rd_regs(input logic [7:0] ra, input int n, output logic [17:0] q [4]);
    logic [7:0] b0, b1, r;
    logic a;
    start();
    xfer({TARGET_ADDR, 1'b0}, 1'b1, r, a);
    xfer(ra, 1'b1, r, a);
    stop();
    start();
    xfer({TARGET_ADDR, 1'b1}, 1'b1, r, a);
    `CHK("read ack", 1'b0, a)
    for (int k = 0; k < n; k++) begin
      xfer(8'hff, 1'b0, b0, a);
      xfer(8'hff, 1'b0, b1, a);
      xfer(8'hff, (k == n - 1), r, a);
      q[k] = {b0[1:0], b1, r};
      `CHK("upper bits", 6'h00, b0[7:2])
    end
    stop();
  endtask : rd_regs
  task automatic wait_boot();
    for (int i = 0; i < 300 && boot_done !== 1'b1; i++)
      @(posedge clk_in);
    `CHK("boot done", 1'b1, boot_done)
  endtask : wait_boot
  task automatic t_boot();
    logic [17:0] q [4];
    wait_boot();
    for (int k = 0; k < SHADOW_CNT; k++)
      `CHK("shadow load", pat(k + 8), bank[k*WORD_W +: WORD_W])
    rd_regs(8'h47, 2, q);
    `CHK("word 71", 18'h0_0000, q[0])
    `CHK("word 72", pat(8), q[1])
  endtask : t_boot
  task automatic t_shadow();
    logic [17:0] q [4];
    wr_reg(TARGET_ADDR, SPEED_INPUT_CONFIG, W72, 1'b1);
    `CHK("band", W72[15], band)
    `CHK("order", W72[14], order)
    `CHK("span", W72[13], span)
    `CHK("source", W72[12:11], src)
    `CHK("max speed", W72[10:0], maxs)
    wr_reg(TARGET_ADDR, STARTUP_ACCEL_CONFIG, W73, 1'b1);
    `CHK("slope", W73[17:8], slope)
    `CHK("rate", W73[7:0], rate)
    `CHK("no nv write", 0, wr_cnt)
    rd_regs(SPEED_INPUT_CONFIG, 2, q);
    `CHK("read 72", W72, q[0])
    `CHK("read 73", W73, q[1])
    wr_reg(7'h54, SPEED_INPUT_CONFIG, 18'h0_0000, 1'b0);
    `CHK("foreign", W72, bank[0 +: WORD_W])
  endtask : t_shadow
  task automatic t_locked();
    logic [17:0] q [4];
    wr_reg(TARGET_ADDR, 8'h03, 18'h1_1111, 1'b1);
    wr_reg(TARGET_ADDR, 8'h1f, 18'h1_1111, 1'b1);
    `CHK("locked writes", 0, wr_cnt)
    wr_reg(TARGET_ADDR, 8'h09, W9, 1'b1);
    `CHK("nv write", 1, wr_cnt)
    `CHK("nv address", 6'h09, wr_addr)
    `CHK("shadow kept", W73, bank[WORD_W +: WORD_W])
    rd_regs(8'h1f, 2, q);
    `CHK("locked 31", pat(31), q[0])
    `CHK("word 32", pat(32), q[1])
  endtask : t_locked
  task automatic t_extra();
    logic [7:0] r;
    logic a;
    start();
    xfer({TARGET_ADDR, 1'b0}, 1'b1, r, a);
    xfer(STARTUP_ACCEL_CONFIG, 1'b1, r, a);
    for (int i = 0; i < 3; i++)
      xfer(8'h00, 1'b1, r, a);
    xfer(8'h5a, 1'b1, r, a);
    `CHK("extra byte nack", 1'b1, a)
    stop();
    `CHK("extra byte dropped", 18'h0_0000, bank[WORD_W +: WORD_W])
  endtask : t_extra
  task automatic t_curve();
    curve_addr <= 6'h28;
    curve_req <= 1'b1;
    @(posedge clk_in);
    curve_req <= 1'b0;
    for (int i = 0; i < 20 && curve_valid !== 1'b1; i++)
      @(posedge clk_in);
    `CHK("curve valid", 1'b1, curve_valid)
    `CHK("curve data", pat(40), curve_data)
  endtask : t_curve
  task automatic t_repower();
    arst_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    wait_boot();
    `CHK("edit lost", pat(8), bank[0 +: WORD_W])
    `CHK("nv applied", W9, bank[WORD_W +: WORD_W])
  endtask : t_repower
  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    fail_count++;
    conclude();
  end
  initial begin
    arst_n_in = 1'b0;
    scl = 1'b1;
    sda_h = 1'b1;
    curve_req = 1'b0;
    curve_addr = 6'h00;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_boot();
    t_shadow();
    t_locked();
    t_extra();
    t_curve();
    t_repower();
    conclude();
  end
endmodule : i2c_shadow_register_port_tb
